/* File: verilog/adcsf_top.sv */
// Converter control: sleep-triggered start, result saturation and adjust, AXI4-Lite registers.
// Assumes a SAR core that reports a signed raw value with a one-cycle done pulse.
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`include "adcsf_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module adcsf_top (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    // AXI4-Lite slave
    input  wire logic [7:0]  AXI_AWADDR,
    input  wire logic        AXI_AWVALID,
    output logic             AXI_AWREADY,
    input  wire logic [31:0] AXI_WDATA,
    input  wire logic [3:0]  AXI_WSTRB,
    input  wire logic        AXI_WVALID,
    output logic             AXI_WREADY,
    output logic [1:0]       AXI_BRESP,
    output logic             AXI_BVALID,
    input  wire logic        AXI_BREADY,
    input  wire logic [7:0]  AXI_ARADDR,
    input  wire logic        AXI_ARVALID,
    output logic             AXI_ARREADY,
    output logic [31:0]      AXI_RDATA,
    output logic [1:0]       AXI_RRESP,
    output logic             AXI_RVALID,
    input  wire logic        AXI_RREADY,
    // Sleep controller
    input  wire logic        SLEEP_HALT,
    output logic             CPU_WAKE,
    // Converter core
    output logic             ANA_ENABLE,
    output logic             ANA_START,
    output logic             ANA_ABORT,
    output logic [4:0]       ANA_CHAN,
    output logic [1:0]       ANA_GAIN,
    output logic [1:0]       ANA_REF,
    output logic             ANA_DIFF,
    input  wire logic        ANA_DONE,
    input  wire logic [11:0] ANA_RAW,
    // Interrupt
    output logic             IRQ
);
    adcsf_pkg::adcsf_state_s_type q;
    adcsf_pkg::adcsf_state_s_type s_nxt;

    logic [9:0]  fmt_code;
    logic        w_fire;
    logic        halt_rise;
    logic        go;
    logic        from_sleep;
    logic        busy;
    logic [15:0] res_pair;
    logic [1:0]  stat_set;
    logic [1:0]  stat_clr;

    // Differential when the field points at a pair
    function automatic logic is_diff(input logic [4:0] ch);
        is_diff = (ch[4:3] != 2'b00) && (ch != 5'h1E) && (ch != 5'h1F);
    endfunction

    function automatic adcsf_pkg::adcsf_gain_type gain_of(input logic [4:0] ch);
        if (ch[4:3] == 2'b01) begin
            gain_of = ch[1] ? adcsf_pkg::GAIN_200 : adcsf_pkg::GAIN_10;
        end else begin
            gain_of = adcsf_pkg::GAIN_1;
        end
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == `ADCSF_CTRL_OFF) || (a == `ADCSF_SEL_OFF) ||
                  (a == `ADCSF_RES_OFF)  || (a == `ADCSF_STAT_OFF) ||
                  (a == `ADCSF_MASK_OFF) || (a == `ADCSF_INFO_OFF);
    endfunction

    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        merge8 = st[0] ? wd[7:0] : old;
    endfunction

    // Result pair built from the stored code and the live adjust bit
    function automatic logic [15:0] pack_res(input logic [9:0] c, input logic la);
        pack_res = la ? {c, 6'h00} : {6'h00, c};
    endfunction

    adcsf_fmt u_fmt (
        .raw  (ANA_RAW),
        .diff (is_diff(q.lock_chan)),
        .code (fmt_code)
    );

    assign busy        = (q.state == adcsf_pkg::ST_CONV);
    assign res_pair    = pack_res(q.code, q.ladj);
    assign w_fire      = q.aw_got && q.w_got && !q.bvalid;
    assign halt_rise   = SLEEP_HALT && !q.halt_d;

    assign AXI_AWREADY = !q.aw_got && !q.bvalid;
    assign AXI_WREADY  = !q.w_got && !q.bvalid;
    assign AXI_BVALID  = q.bvalid;
    assign AXI_BRESP   = q.bresp;
    assign AXI_ARREADY = !q.rvalid;
    assign AXI_RVALID  = q.rvalid;
    assign AXI_RDATA   = q.rdata;
    assign AXI_RRESP   = q.rresp;
    assign CPU_WAKE    = q.wake_p;
    assign ANA_ENABLE  = q.en;
    assign ANA_START   = q.start_p;
    assign ANA_ABORT   = q.abort_p;
    assign ANA_CHAN    = q.lock_chan;
    assign ANA_GAIN    = gain_of(q.lock_chan);
    assign ANA_REF     = q.refsel;
    assign ANA_DIFF    = is_diff(q.lock_chan);
    assign IRQ         = |(q.stat & q.mask);

    always_comb begin
        s_nxt       = q;
        go          = 1'b0;
        from_sleep  = 1'b0;
        stat_set    = 2'b00;
        stat_clr    = 2'b00;
        s_nxt.start_p = 1'b0;
        s_nxt.abort_p = 1'b0;
        s_nxt.wake_p  = 1'b0;
        s_nxt.halt_d  = SLEEP_HALT;
        // Address and data captured in either order
        if (AXI_AWVALID && !q.aw_got && !q.bvalid) begin
            s_nxt.aw_got  = 1'b1;
            s_nxt.aw_addr = AXI_AWADDR;
        end
        if (AXI_WVALID && !q.w_got && !q.bvalid) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = AXI_WDATA;
            s_nxt.wstrb = AXI_WSTRB;
        end
        if (q.bvalid && AXI_BREADY) begin
            s_nxt.bvalid = 1'b0;
        end
        if (w_fire) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = addr_ok(q.aw_addr) ? `ADCSF_RESP_OKAY : `ADCSF_RESP_SLVERR;
            if (q.aw_addr == `ADCSF_CTRL_OFF) begin
                if (q.wstrb[0]) begin
                    s_nxt.en   = q.wdata[`ADCSF_CTRL_EN];
                    s_nxt.free = q.wdata[`ADCSF_CTRL_FREE];
                    go         = q.wdata[`ADCSF_CTRL_START];
                end
            end else if (q.aw_addr == `ADCSF_SEL_OFF) begin
                {s_nxt.refsel, s_nxt.ladj, s_nxt.chan} = merge8({q.refsel, q.ladj, q.chan},
                                                                q.wdata, q.wstrb);
            end else if (q.aw_addr == `ADCSF_STAT_OFF) begin
                stat_clr = q.wstrb[0] ? q.wdata[1:0] : 2'b00;
            end else if (q.aw_addr == `ADCSF_MASK_OFF) begin
                s_nxt.mask = q.wstrb[0] ? q.wdata[1:0] : q.mask;
            end
        end
        // Sleep start only from an enabled, idle, single-mode converter with done unmasked
        if (halt_rise && q.en && s_nxt.en && !busy && !s_nxt.free && s_nxt.mask[`ADCSF_EV_DONE])
        begin
            go         = 1'b1;
            from_sleep = 1'b1;
        end
        case (q.state)
            adcsf_pkg::ST_IDLE: begin
                if (go && s_nxt.en) begin
                    s_nxt.state      = adcsf_pkg::ST_CONV;
                    s_nxt.lock_chan  = s_nxt.chan;
                    s_nxt.start_p    = 1'b1;
                    s_nxt.sleep_conv = from_sleep;
                end else begin
                    s_nxt.lock_chan  = s_nxt.chan;
                end
            end
            adcsf_pkg::ST_CONV: begin
                if (!s_nxt.en) begin
                    s_nxt.state      = adcsf_pkg::ST_IDLE;
                    s_nxt.abort_p    = 1'b1;
                    s_nxt.sleep_conv = 1'b0;
                    stat_set[`ADCSF_EV_ABORT] = 1'b1;
                end else if (ANA_DONE) begin
                    s_nxt.code      = fmt_code;
                    s_nxt.code_diff = is_diff(q.lock_chan);
                    stat_set[`ADCSF_EV_DONE] = 1'b1;
                    s_nxt.wake_p    = q.sleep_conv && SLEEP_HALT;
                    s_nxt.sleep_conv = 1'b0;
                    if (s_nxt.free) begin
                        s_nxt.lock_chan = s_nxt.chan;
                        s_nxt.start_p   = 1'b1;
                    end else begin
                        s_nxt.state     = adcsf_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                s_nxt.state = adcsf_pkg::ST_IDLE;
            end
        endcase
        // Hardware set wins over software clear
        s_nxt.stat = (q.stat & ~stat_clr) | stat_set;
        if (q.rvalid && AXI_RREADY) begin
            s_nxt.rvalid = 1'b0;
        end
        if (AXI_ARVALID && !q.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = addr_ok(AXI_ARADDR) ? `ADCSF_RESP_OKAY : `ADCSF_RESP_SLVERR;
            if (AXI_ARADDR == `ADCSF_CTRL_OFF) begin
                s_nxt.rdata = {29'h0, q.free, busy, q.en};
            end else if (AXI_ARADDR == `ADCSF_SEL_OFF) begin
                s_nxt.rdata = {24'h0, q.refsel, q.ladj, q.chan};
            end else if (AXI_ARADDR == `ADCSF_RES_OFF) begin
                s_nxt.rdata = {16'h0, res_pair};
            end else if (AXI_ARADDR == `ADCSF_STAT_OFF) begin
                s_nxt.rdata = {30'h0, q.stat};
            end else if (AXI_ARADDR == `ADCSF_MASK_OFF) begin
                s_nxt.rdata = {30'h0, q.mask};
            end else if (AXI_ARADDR == `ADCSF_INFO_OFF) begin
                s_nxt.rdata = {29'h0, q.code_diff, q.sleep_conv, busy};
            end else begin
                s_nxt.rdata = 32'h0;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            q       <= '0;
            q.state <= adcsf_pkg::ST_IDLE;
        end else begin
            q <= s_nxt;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    sleep_start_a: assert property (
        $rose(SLEEP_HALT) && q.en && !busy && !q.free && q.mask[0] && !w_fire
        ##1 q.halt_d |-> ANA_START && busy && q.sleep_conv)
        else $error("sleep halt did not start a conversion");

    sleep_only_once_a: assert property (
        SLEEP_HALT && q.halt_d && !busy && !w_fire |=> !ANA_START)
        else $error("conversion started without new halt or write");

    done_flag_a: assert property (
        busy && q.en && ANA_DONE && !w_fire |=> q.stat[0] && (q.code == $past(fmt_code)))
        else $error("done flag or result not captured");

    wake_a: assert property (
        busy && q.en && ANA_DONE && q.sleep_conv && SLEEP_HALT && !w_fire |=> CPU_WAKE ##1 !CPU_WAKE)
        else $error("sleep conversion did not wake the cpu");

    en_kept_a: assert property (
        q.en && !w_fire |=> q.en)
        else $error("enable changed without a write");

    abort_a: assert property (
        busy |-> q.en)
        else $error("conversion running while disabled");

    left_adj_a: assert property (
        q.ladj |-> (AXI_ARVALID && !q.rvalid && AXI_ARADDR == `ADCSF_RES_OFF)
        ##0 1'b1 |=> (!q.ladj || q.rdata[15:0] == {q.code, 6'h00}) || $changed(q.code))
        else $error("left adjusted pair wrong");

    diff_sat_hi_a: assert property (
        is_diff(q.lock_chan) && $signed(ANA_RAW) > 12'sh1FF |-> fmt_code == 10'h1FF)
        else $error("positive saturation wrong");

    diff_sat_lo_a: assert property (
        is_diff(q.lock_chan) && $signed(ANA_RAW) < 12'shE00 |-> fmt_code == 10'h200)
        else $error("negative saturation wrong");

    se_clip_a: assert property (
        !is_diff(q.lock_chan) && $signed(ANA_RAW) > 12'sh3FF |-> fmt_code == 10'h3FF)
        else $error("single ended clip wrong");

    irq_set_a: assert property (
        q.mask[0] && busy && q.en && ANA_DONE && !w_fire |=> IRQ)
        else $error("interrupt not raised on done");

    diff_sign_a: assert property (
        busy && q.en && ANA_DONE && is_diff(q.lock_chan) && !w_fire
        |=> q.code[9] == $past(ANA_RAW[11]))
        else $error("differential sign bit wrong");

    abort_stop_a: assert property (
        busy && w_fire && q.aw_addr == `ADCSF_CTRL_OFF && q.wstrb[0] && !q.wdata[0]
        |=> ANA_ABORT && !busy && q.stat[1])
        else $error("enable clear did not terminate the conversion");

    sleep_done_c: cover property (q.sleep_conv && ANA_DONE ##1 CPU_WAKE);
    abort_c: cover property (busy ##1 ANA_ABORT);
    diff_left_c: cover property (q.code_diff && q.ladj && q.code[9]);
    free_run_c: cover property (busy && ANA_DONE && q.free ##1 ANA_START);

endmodule // adcsf_top
`default_nettype wire

/* File: verilog/adcsf_regs.svh */
// Register offsets, field positions, response codes and saturation limits of the converter control block.
// Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
// Function
// - Sleep halt starts conversion once clock stopped
// - Done interrupt wakes CPU from sleep
// - Earlier wake: conversion continues, done still raised
// - No return to sleep without new halt
// - Other sleep modes leave enable unchanged
// - Result readable once done flag set
// - Single-ended result unsigned, 0x000 to 0x3FF
// - Differential result two's complement 0x200 to 0x1FF
// - Bit nine in high byte is sign
// - Differential result saturates at both full scales
// - Left adjust selects upper or lower ten bits
// - Same input allowed as both differential inputs
// - Adjust change shows immediately, even mid-conversion
// - Five-bit field selects input, pair and gain
// - Clearing enable terminates running conversion
`ifndef ADCSF_REGS_SVH
`define ADCSF_REGS_SVH

`define ADCSF_CTRL_OFF   8'h00
`define ADCSF_SEL_OFF    8'h04
`define ADCSF_RES_OFF    8'h08
`define ADCSF_STAT_OFF   8'h0C
`define ADCSF_MASK_OFF   8'h10
`define ADCSF_INFO_OFF   8'h14

`define ADCSF_CTRL_EN    0
`define ADCSF_CTRL_START 1
`define ADCSF_CTRL_FREE  2

`define ADCSF_SEL_LADJ   5

`define ADCSF_EV_DONE    0
`define ADCSF_EV_ABORT   1

`define ADCSF_RESP_OKAY  2'b00
`define ADCSF_RESP_SLVERR 2'b10

`define ADCSF_SE_MAX     12'sh3FF
`define ADCSF_DIFF_MAX   12'sh1FF
`define ADCSF_DIFF_MIN   12'shE00

`endif

/* File: verilog/adcsf_pkg.sv */
// Types shared by the converter control block.
// Assumes the offsets and field positions come from adcsf_regs.svh.
`default_nettype none
package adcsf_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } adcsf_state_type;

    typedef enum logic [1:0] {
        GAIN_1   = 2'b00,
        GAIN_10  = 2'b01,
        GAIN_200 = 2'b10
    } adcsf_gain_type;

    typedef struct packed {
        adcsf_state_type state;
        logic            en;
        logic            free;
        logic [1:0]      refsel;
        logic [4:0]      chan;
        logic            ladj;
        logic [4:0]      lock_chan;
        logic [9:0]      code;
        logic            code_diff;
        logic [1:0]      stat;
        logic [1:0]      mask;
        logic            halt_d;
        logic            sleep_conv;
        logic            aw_got;
        logic [7:0]      aw_addr;
        logic            w_got;
        logic [31:0]     wdata;
        logic [3:0]      wstrb;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
        logic            start_p;
        logic            abort_p;
        logic            wake_p;
    } adcsf_state_s_type;

endpackage
`default_nettype wire

/* File: verilog/adcsf_fmt.sv */
// Saturation of the raw converter value into a 10-bit result code.
// Assumes the raw value is a signed estimate wider than the result.
`include "adcsf_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module adcsf_fmt (
    // Raw value and mode
    input  wire logic signed [11:0] raw,
    input  wire logic               diff,
    // Result code
    output logic             [9:0]  code
);
    always_comb begin
        if (diff) begin
            if (raw > `ADCSF_DIFF_MAX) begin
                code = 10'h1FF;
            end else if (raw < `ADCSF_DIFF_MIN) begin
                code = 10'h200;
            end else begin
                code = raw[9:0];
            end
        end else begin
            if (raw < 12'sh000) begin
                code = 10'h000;
            end else if (raw > `ADCSF_SE_MAX) begin
                code = 10'h3FF;
            end else begin
                code = raw[9:0];
            end
        end
    end
endmodule // adcsf_fmt
`default_nettype wire

/* File: dv/adcsf_core_model.sv */
// Behavioural converter core answering start pulses after a set delay.
// Assumes start and abort pulses from adcsf_top on the same clock.
`timescale 1ns/1ps
`default_nettype none
module adcsf_core_model (
    // Clock and control
    input  wire logic        clk,
    input  wire logic        start,
    input  wire logic        abort,
    // Value to report and delay in cycles
    input  wire logic [11:0] value,
    input  var  int          delay,
    // Result
    output logic             done,
    output logic [11:0]      raw
);
    int cnt = 0;
    initial begin
        done = 1'b0;
        raw  = 12'hA5A;
    end
    always @(posedge clk) begin
        done <= 1'b0;
        // Raw value is garbage outside the done cycle
        raw  <= ~raw;
        if (abort) begin
            cnt <= 0;
        end else if (start) begin
            cnt <= delay;
        end else if (cnt == 1) begin
            cnt  <= 0;
            done <= 1'b1;
            raw  <= value;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule // adcsf_core_model
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the converter control block.
// Assumes adcsf_top and adcsf_core_model are compiled before it.
`include "adcsf_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0, nrst = 1'b0, halt = 1'b0, bready = 1'b0, rready = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic        awready, wready, bvalid, arready, rvalid, wake, irq;
    logic        a_en, a_start, a_abort, a_diff, a_done;
    logic [1:0]  bresp, rresp, a_gain, a_ref;
    logic [4:0]  a_chan;
    logic [11:0] a_raw, value = 12'h000;
    int          delay = 5, errors = 0, samples_checked = 0;
    int          n_start = 0, n_wake = 0, n_abort = 0;

    adcsf_top DUT (
        .SYS_CLK(clk), .NRST(nrst),
        .AXI_AWADDR(awaddr), .AXI_AWVALID(awvalid), .AXI_AWREADY(awready),
        .AXI_WDATA(wdata), .AXI_WSTRB(wstrb), .AXI_WVALID(wvalid), .AXI_WREADY(wready),
        .AXI_BRESP(bresp), .AXI_BVALID(bvalid), .AXI_BREADY(bready),
        .AXI_ARADDR(araddr), .AXI_ARVALID(arvalid), .AXI_ARREADY(arready),
        .AXI_RDATA(rdata), .AXI_RRESP(rresp), .AXI_RVALID(rvalid), .AXI_RREADY(rready),
        .SLEEP_HALT(halt), .CPU_WAKE(wake), .ANA_ENABLE(a_en), .ANA_START(a_start),
        .ANA_ABORT(a_abort), .ANA_CHAN(a_chan), .ANA_GAIN(a_gain), .ANA_REF(a_ref),
        .ANA_DIFF(a_diff), .ANA_DONE(a_done), .ANA_RAW(a_raw), .IRQ(irq)
    );
    adcsf_core_model core (
        .clk(clk), .start(a_start), .abort(a_abort), .value(value), .delay(delay),
        .done(a_done), .raw(a_raw)
    );

    initial begin
        forever #5 clk = ~clk;
    end
    // Pulse counters, sampled mid-cycle
    always @(negedge clk) begin
        if (a_start === 1'b1) n_start++;
        if (wake === 1'b1) n_wake++;
        if (a_abort === 1'b1) n_abort++;
    end

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, ka, kw, kb;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(negedge clk);
            ka = awready;
            kw = wready;
            @(posedge clk);
            if (pa && ka) begin
                awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (pw && kw) begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
        end while (pa || pw);
        bready <= 1'b1;
        do begin
            @(negedge clk);
            kb = bvalid;
            r  = bresp;
            @(posedge clk);
        end while (!kb);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic k;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge clk);
            k = arready;
            @(posedge clk);
        end while (!k);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do begin
            @(negedge clk);
            k = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
        end while (!k);
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        check("bresp", {30'h0, `ADCSF_RESP_OKAY}, {30'h0, r});
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check(nm, e, d);
    endtask

    task automatic wait_done();
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        n = 0;
        do begin
            axi_rd(`ADCSF_STAT_OFF, d, r);
            n++;
        end while (d[`ADCSF_EV_DONE] !== 1'b1 && n < 40);
        check("done flag", 32'h1, {31'h0, d[`ADCSF_EV_DONE]});
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rd_chk("status", `ADCSF_STAT_OFF, 32'h0);
        check("irq", 32'h0, {31'h0, irq});
        axi_rd(8'h1C, d, r);
        check("rresp", {30'h0, `ADCSF_RESP_SLVERR}, {30'h0, r});
        check("rdata", 32'h0, d);
        axi_wr(8'h1C, 32'hFF, r);
        check("bresp", {30'h0, `ADCSF_RESP_SLVERR}, {30'h0, r});
        $display("test reset done");
    endtask

    task automatic chan(input logic [4:0] s, input logic [2:0] e);
        wr(`ADCSF_SEL_OFF, {27'h0, s});
        repeat (2) @(negedge clk);
        check("diff", {31'h0, e[2]}, {31'h0, a_diff});
        check("chan", {27'h0, s}, {27'h0, a_chan});
        if (e[2]) check("gain", {30'h0, e[1:0]}, {30'h0, a_gain});
    endtask

    task automatic conv(input logic [7:0] s, input logic [11:0] v, input logic [31:0] e);
        wr(`ADCSF_SEL_OFF, {24'h0, s});
        value <= v;
        wr(`ADCSF_CTRL_OFF, 32'h3);
        wait_done();
        rd_chk("result", `ADCSF_RES_OFF, e);
        wr(`ADCSF_STAT_OFF, 32'h1);
    endtask

    task automatic t_conv();
        conv(8'h00, 12'h064, 32'h0064);
        conv(8'h00, 12'hFFB, 32'h0000);
        conv(8'h00, 12'h7D0, 32'h03FF);
        conv(8'h09, 12'h258, 32'h01FF);
        conv(8'h09, 12'hD44, 32'h0200);
        conv(8'h0B, 12'hE01, 32'h0201);
        conv(8'h2D, 12'hE70, 32'h9C00);
        delay <= 40;
        wr(`ADCSF_SEL_OFF, 32'hCD);
        check("ref", 32'h3, {30'h0, a_ref});
        wr(`ADCSF_CTRL_OFF, 32'h3);
        rd_chk("result", `ADCSF_RES_OFF, 32'h0270);
        rd_chk("info", `ADCSF_INFO_OFF, 32'h5);
        wait_done();
        wr(`ADCSF_STAT_OFF, 32'h1);
        delay <= 5;
        $display("test conv done");
    endtask

    task automatic t_sleep();
        int s, w, n;
        wr(`ADCSF_SEL_OFF, 32'h0);
        wr(`ADCSF_MASK_OFF, 32'h1);
        wr(`ADCSF_CTRL_OFF, 32'h1);
        value <= 12'h155;
        s = n_start;
        w = n_wake;
        n = 0;
        halt <= 1'b1;
        while (n_wake == w && n < 40) begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(negedge clk);
        check("starts", 32'h1, n_start - s);
        check("wakes", 32'h1, n_wake - w);
        check("irq", 32'h1, {31'h0, irq});
        repeat (20) @(posedge clk);
        check("restarts", 32'h1, n_start - s);
        rd_chk("ctrl", `ADCSF_CTRL_OFF, 32'h1);
        rd_chk("result", `ADCSF_RES_OFF, 32'h0155);
        halt <= 1'b0;
        wr(`ADCSF_STAT_OFF, 32'h1);
        halt <= 1'b1;
        @(posedge clk);
        halt <= 1'b0;
        wait_done();
        check("wakes", 32'h1, n_wake - w);
        check("irq", 32'h1, {31'h0, irq});
        wr(`ADCSF_STAT_OFF, 32'h1);
        wr(`ADCSF_CTRL_OFF, 32'h0);
        wr(`ADCSF_CTRL_OFF, 32'h1);
        $display("test sleep done");
    endtask

    task automatic t_abort();
        int a;
        delay <= 50;
        wr(`ADCSF_MASK_OFF, 32'h0);
        wr(`ADCSF_CTRL_OFF, 32'h3);
        a = n_abort;
        wr(`ADCSF_CTRL_OFF, 32'h0);
        repeat (60) @(posedge clk);
        check("aborts", 32'h1, n_abort - a);
        check("enable", 32'h0, {31'h0, a_en});
        rd_chk("status", `ADCSF_STAT_OFF, 32'h2);
        check("irq masked", 32'h0, {31'h0, irq});
        wr(`ADCSF_MASK_OFF, 32'h2);
        @(negedge clk);
        check("irq", 32'h1, {31'h0, irq});
        wr(`ADCSF_STAT_OFF, 32'h2);
        @(negedge clk);
        check("irq cleared", 32'h0, {31'h0, irq});
        delay <= 5;
        $display("test abort done");
    endtask

    task automatic t_free();
        int s;
        s = n_start;
        wr(`ADCSF_CTRL_OFF, 32'h7);
        repeat (20) @(posedge clk);
        wr(`ADCSF_CTRL_OFF, 32'h1);
        repeat (20) @(posedge clk);
        check("free starts", 32'h4, n_start - s);
        rd_chk("ctrl", `ADCSF_CTRL_OFF, 32'h1);
        rd_chk("status", `ADCSF_STAT_OFF, 32'h1);
        wr(`ADCSF_STAT_OFF, 32'h1);
        $display("test free done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #100us;
        errors++;
        results();
    end

    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        chan(5'h00, 3'b000);
        chan(5'h09, 3'b101);
        chan(5'h0B, 3'b110);
        chan(5'h10, 3'b100);
        chan(5'h08, 3'b101);
        chan(5'h1F, 3'b000);
        t_conv();
        t_sleep();
        t_abort();
        t_free();
        results();
    end
endmodule // tb_top
`default_nettype wire
